// ### shared/brt_consts.vh
`ifndef BRT_CONSTS_VH
`define BRT_CONSTS_VH

// Data path
`define BRT_WIDTH               18
`define BRT_COUNT_WIDTH         16

// Register bus
`define BRT_ADDR_WIDTH          5
`define BRT_DATA_WIDTH          32
`define BRT_REG_CTRL            5'h00
`define BRT_REG_STATUS          5'h04
`define BRT_REG_A2B_DATA        5'h08
`define BRT_REG_B2A_DATA        5'h0C
`define BRT_REG_A2B_COUNT       5'h10
`define BRT_REG_B2A_COUNT       5'h14
`define BRT_RESP_OKAY           2'b00
`define BRT_RESP_SLVERR         2'b10

// Control register fields, write one to act, read as zero
`define BRT_CTRL_A2B_SW_CAPTURE 0
`define BRT_CTRL_B2A_SW_CAPTURE 1
`define BRT_CTRL_CLEAR_COUNTS   2

// Status register fields
`define BRT_STAT_A2B_TRANSP     0
`define BRT_STAT_B2A_TRANSP     1
`define BRT_STAT_A2B_DRIVING    2
`define BRT_STAT_B2A_DRIVING    3
`define BRT_STAT_A2B_CLOCK      4
`define BRT_STAT_B2A_CLOCK      5

// Reset values
`define BRT_RESET_WORD          32'h0000_0000
`define BRT_RESET_STAGE         1'b0
`define BRT_RESET_CTL           6'h08

// Timing
`define BRT_SETTLE_CYCLES       2'h3

`endif

// ### core/brt_stage.v
`timescale 1ns/1ps
`include "brt_consts.vh"

module brt_stage #(
  parameter WIDTH = 18
) (
  // Clock and reset
  input  wire             i_clock,
  input  wire             i_rst_n,
  // Stage control
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_transparent,
  input  wire             i_capture,
  // Stored value
  output wire [WIDTH-1:0] o_data
);

  reg [WIDTH-1:0] stored;

  assign o_data = stored;

  // Same cell for every bit position
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          stored[g] <= `BRT_RESET_STAGE;
        end else if (i_transparent) begin
          stored[g] <= i_data[g];
        end else if (i_capture) begin
          stored[g] <= i_data[g];
        end
        // Otherwise hold
      end
    end
  endgenerate

endmodule // brt_stage

// ### core/brt_transceiver.v
`timescale 1ns/1ps
`include "brt_consts.vh"

// Function
// - Eighteen data bits each way, every bit with identical storage and enables.
// - Each direction uses only its own drive, transparency and capture controls.
// - A-to-B transparency high passes port A straight to port B.
// - Transparency low, clock steady: A-to-B stage holds, ignores port A except on a software capture write.
// - Transparency low: rising capture clock edge loads port A into stage.
// - Steady-high clock only keeps value if high when transparency dropped.
// - A-to-B drive enable high drives port B, low floats it.
// - B-to-A drive enable low drives port A, high floats it.
// - B-to-A path mirrors A-to-B with transparent, hold and capture modes.
// - Port A feeds A-to-B, is B-to-A output; agent must not contend.
// - Port B feeds B-to-A, is A-to-B output; agent must not contend.
module brt_transceiver #(
  parameter WIDTH       = `BRT_WIDTH,
  parameter COUNT_WIDTH = `BRT_COUNT_WIDTH
) (
  // Clock and reset
  input  wire                       I_CLOCK,
  input  wire                       I_RST_N,
  // Direction controls
  input  wire                       I_A_TO_B_DRIVE_ENABLE,
  input  wire                       I_B_TO_A_DRIVE_ENABLE_N,
  input  wire                       I_A_TO_B_TRANSPARENT_ENABLE,
  input  wire                       I_B_TO_A_TRANSPARENT_ENABLE,
  input  wire                       I_A_TO_B_CAPTURE_CLOCK,
  input  wire                       I_B_TO_A_CAPTURE_CLOCK,
  // Port A lines
  input  wire [WIDTH-1:0]           I_PORT_A_LINES,
  output wire [WIDTH-1:0]           O_PORT_A_LINES,
  output reg  [WIDTH-1:0]           O_PORT_A_LINES_OE,
  // Port B lines
  input  wire [WIDTH-1:0]           I_PORT_B_LINES,
  output wire [WIDTH-1:0]           O_PORT_B_LINES,
  output reg  [WIDTH-1:0]           O_PORT_B_LINES_OE,
  // AXI4-Lite write address
  input  wire                       I_AWVALID,
  output reg                        O_AWREADY,
  input  wire [`BRT_ADDR_WIDTH-1:0] I_AWADDR,
  input  wire [2:0]                 I_AWPROT,
  // AXI4-Lite write data
  input  wire                       I_WVALID,
  output reg                        O_WREADY,
  input  wire [`BRT_DATA_WIDTH-1:0] I_WDATA,
  input  wire [3:0]                 I_WSTRB,
  // AXI4-Lite write response
  output reg                        O_BVALID,
  input  wire                       I_BREADY,
  output reg  [1:0]                 O_BRESP,
  // AXI4-Lite read address
  input  wire                       I_ARVALID,
  output reg                        O_ARREADY,
  input  wire [`BRT_ADDR_WIDTH-1:0] I_ARADDR,
  input  wire [2:0]                 I_ARPROT,
  // AXI4-Lite read data
  output reg                        O_RVALID,
  input  wire                       I_RREADY,
  output reg  [`BRT_DATA_WIDTH-1:0] O_RDATA,
  output reg  [1:0]                 O_RRESP
);

  // Reset release through two flops
  reg rst_meta;
  reg rst_sync;
  wire rst_n = rst_sync;

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Pin synchronisers; wide buses may skew by a cycle while changing
  wire [5:0]       ctl_pins = {I_B_TO_A_CAPTURE_CLOCK, I_A_TO_B_CAPTURE_CLOCK,
                               I_B_TO_A_DRIVE_ENABLE_N, I_A_TO_B_DRIVE_ENABLE,
                               I_B_TO_A_TRANSPARENT_ENABLE, I_A_TO_B_TRANSPARENT_ENABLE};
  reg  [5:0]       ctl_meta;
  reg  [5:0]       ctl_sync;
  reg  [WIDTH-1:0] a_meta;
  reg  [WIDTH-1:0] a_sync;
  reg  [WIDTH-1:0] b_meta;
  reg  [WIDTH-1:0] b_sync;

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      // Enables leave reset inactive, so no bus is grabbed at release
      ctl_meta <= `BRT_RESET_CTL;
      ctl_sync <= `BRT_RESET_CTL;
      a_meta   <= {WIDTH{1'b0}};
      a_sync   <= {WIDTH{1'b0}};
      b_meta   <= {WIDTH{1'b0}};
      b_sync   <= {WIDTH{1'b0}};
    end else begin
      ctl_meta <= ctl_pins;
      ctl_sync <= ctl_meta;
      a_meta   <= I_PORT_A_LINES;
      a_sync   <= a_meta;
      b_meta   <= I_PORT_B_LINES;
      b_sync   <= b_meta;
    end
  end

  wire a2b_transp  = ctl_sync[0];
  wire b2a_transp  = ctl_sync[1];
  wire a2b_drive   = ctl_sync[2];
  wire b2a_drive_n = ctl_sync[3];
  wire a2b_clk     = ctl_sync[4];
  wire b2a_clk     = ctl_sync[5];

  // Edge detect; blind until the synchronisers hold real pin levels
  reg [1:0] settle;
  reg       a2b_clk_prev;
  reg       b2a_clk_prev;
  wire      settled = (settle == `BRT_SETTLE_CYCLES);

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      settle       <= 2'h0;
      a2b_clk_prev <= 1'b1;
      b2a_clk_prev <= 1'b1;
    end else begin
      if (!settled) begin
        settle <= settle + 2'h1;
      end
      a2b_clk_prev <= a2b_clk;
      b2a_clk_prev <= b2a_clk;
    end
  end

  // Only low-to-high counts, so a clock already high at the drop keeps data
  wire a2b_edge = settled & a2b_clk & ~a2b_clk_prev;
  wire b2a_edge = settled & b2a_clk & ~b2a_clk_prev;

  // Software capture strobes
  reg  a2b_sw_capture;
  reg  b2a_sw_capture;
  reg  clear_counts;

  // Each direction sees only its own controls
  wire a2b_capture = ~a2b_transp & (a2b_edge | a2b_sw_capture);
  wire b2a_capture = ~b2a_transp & (b2a_edge | b2a_sw_capture);

  wire [WIDTH-1:0] a2b_data;
  wire [WIDTH-1:0] b2a_data;

  brt_stage #(
    .WIDTH         (WIDTH)
  ) u_a2b_stage (
    .i_clock       (I_CLOCK),
    .i_rst_n       (rst_n),
    .i_data        (a_sync),
    .i_transparent (a2b_transp),
    .i_capture     (a2b_capture),
    .o_data        (a2b_data)
  );

  brt_stage #(
    .WIDTH         (WIDTH)
  ) u_b2a_stage (
    .i_clock       (I_CLOCK),
    .i_rst_n       (rst_n),
    .i_data        (b_sync),
    .i_transparent (b2a_transp),
    .i_capture     (b2a_capture),
    .o_data        (b2a_data)
  );

  // Stages run regardless of enables; enables gate only the drivers
  assign O_PORT_B_LINES = a2b_data;
  assign O_PORT_A_LINES = b2a_data;

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_PORT_A_LINES_OE <= {WIDTH{1'b0}};
      O_PORT_B_LINES_OE <= {WIDTH{1'b0}};
    end else begin
      O_PORT_B_LINES_OE <= {WIDTH{a2b_drive}};
      O_PORT_A_LINES_OE <= {WIDTH{~b2a_drive_n}};
    end
  end

  // Capture counters
  reg [COUNT_WIDTH-1:0] a2b_count;
  reg [COUNT_WIDTH-1:0] b2a_count;

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      a2b_count <= {COUNT_WIDTH{1'b0}};
      b2a_count <= {COUNT_WIDTH{1'b0}};
    end else begin
      if (clear_counts) begin
        a2b_count <= {{(COUNT_WIDTH-1){1'b0}}, a2b_capture};
        b2a_count <= {{(COUNT_WIDTH-1){1'b0}}, b2a_capture};
      end else begin
        a2b_count <= a2b_count + {{(COUNT_WIDTH-1){1'b0}}, a2b_capture};
        b2a_count <= b2a_count + {{(COUNT_WIDTH-1){1'b0}}, b2a_capture};
      end
    end
  end

  // Write channel: address and data held until both are present
  reg                        aw_hold;
  reg                        w_hold;
  reg  [`BRT_ADDR_WIDTH-1:0] aw_addr;
  reg  [`BRT_DATA_WIDTH-1:0] w_data;
  reg  [3:0]                 w_strb;
  wire                       aw_take = I_AWVALID & O_AWREADY;
  wire                       w_take  = I_WVALID & O_WREADY;
  wire                       do_write = aw_hold & w_hold & ~O_BVALID;
  reg                        next_aw_hold;
  reg                        next_w_hold;
  reg                        next_bvalid;
  reg                        wr_mapped;

  always @* begin
    next_aw_hold = (aw_hold | aw_take) & ~do_write;
    next_w_hold  = (w_hold | w_take) & ~do_write;
    next_bvalid  = do_write | (O_BVALID & ~I_BREADY);
    case (aw_addr[`BRT_ADDR_WIDTH-1:2])
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold        <= 1'b0;
      w_hold         <= 1'b0;
      aw_addr        <= {`BRT_ADDR_WIDTH{1'b0}};
      w_data         <= `BRT_RESET_WORD;
      w_strb         <= 4'h0;
      O_AWREADY      <= 1'b0;
      O_WREADY       <= 1'b0;
      O_BVALID       <= 1'b0;
      O_BRESP        <= `BRT_RESP_OKAY;
      a2b_sw_capture <= 1'b0;
      b2a_sw_capture <= 1'b0;
      clear_counts   <= 1'b0;
    end else begin
      aw_hold   <= next_aw_hold;
      w_hold    <= next_w_hold;
      O_AWREADY <= ~next_aw_hold & ~next_bvalid;
      O_WREADY  <= ~next_w_hold & ~next_bvalid;
      O_BVALID  <= next_bvalid;
      if (aw_take) begin
        aw_addr <= I_AWADDR;
      end
      if (w_take) begin
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      a2b_sw_capture <= 1'b0;
      b2a_sw_capture <= 1'b0;
      clear_counts   <= 1'b0;
      if (do_write) begin
        O_BRESP <= wr_mapped ? `BRT_RESP_OKAY : `BRT_RESP_SLVERR;
        // Read-only registers ignore writes but answer OKAY
        if (({aw_addr[`BRT_ADDR_WIDTH-1:2], 2'b00} == `BRT_REG_CTRL) && w_strb[0]) begin
          a2b_sw_capture <= w_data[`BRT_CTRL_A2B_SW_CAPTURE];
          b2a_sw_capture <= w_data[`BRT_CTRL_B2A_SW_CAPTURE];
          clear_counts   <= w_data[`BRT_CTRL_CLEAR_COUNTS];
        end
      end
    end
  end

  // Read channel
  wire                       ar_take = I_ARVALID & O_ARREADY;
  reg                        next_rvalid;
  reg  [`BRT_DATA_WIDTH-1:0] rd_word;
  reg                        rd_mapped;

  always @* begin
    next_rvalid = ar_take | (O_RVALID & ~I_RREADY);
    rd_word     = `BRT_RESET_WORD;
    rd_mapped   = 1'b1;
    case ({I_ARADDR[`BRT_ADDR_WIDTH-1:2], 2'b00})
      `BRT_REG_CTRL: begin
        rd_word = `BRT_RESET_WORD;
      end
      `BRT_REG_STATUS: begin
        rd_word[`BRT_STAT_A2B_TRANSP]  = a2b_transp;
        rd_word[`BRT_STAT_B2A_TRANSP]  = b2a_transp;
        rd_word[`BRT_STAT_A2B_DRIVING] = O_PORT_B_LINES_OE[0];
        rd_word[`BRT_STAT_B2A_DRIVING] = O_PORT_A_LINES_OE[0];
        rd_word[`BRT_STAT_A2B_CLOCK]   = a2b_clk;
        rd_word[`BRT_STAT_B2A_CLOCK]   = b2a_clk;
      end
      `BRT_REG_A2B_DATA: begin
        rd_word[WIDTH-1:0] = a2b_data;
      end
      `BRT_REG_B2A_DATA: begin
        rd_word[WIDTH-1:0] = b2a_data;
      end
      `BRT_REG_A2B_COUNT: begin
        rd_word[COUNT_WIDTH-1:0] = a2b_count;
      end
      `BRT_REG_B2A_COUNT: begin
        rd_word[COUNT_WIDTH-1:0] = b2a_count;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= `BRT_RESET_WORD;
      O_RRESP   <= `BRT_RESP_OKAY;
    end else begin
      O_ARREADY <= ~next_rvalid;
      O_RVALID  <= next_rvalid;
      if (ar_take) begin
        O_RDATA <= rd_word;
        O_RRESP <= rd_mapped ? `BRT_RESP_OKAY : `BRT_RESP_SLVERR;
      end
    end
  end

endmodule // brt_transceiver

// ### verification/brt_props.sv
`timescale 1ns/1ps

module brt_props #(
  parameter WIDTH = 18
) (
  // Controls
  input wire             I_CLOCK,
  input wire             I_RST_N,
  input wire             I_A_TO_B_DRIVE_ENABLE,
  input wire             I_B_TO_A_DRIVE_ENABLE_N,
  input wire             I_A_TO_B_TRANSPARENT_ENABLE,
  input wire             I_B_TO_A_TRANSPARENT_ENABLE,
  input wire             I_A_TO_B_CAPTURE_CLOCK,
  input wire             I_B_TO_A_CAPTURE_CLOCK,
  // Lines
  input wire [WIDTH-1:0] I_PORT_A_LINES,
  input wire [WIDTH-1:0] O_PORT_A_LINES,
  input wire [WIDTH-1:0] O_PORT_A_LINES_OE,
  input wire [WIDTH-1:0] I_PORT_B_LINES,
  input wire [WIDTH-1:0] O_PORT_B_LINES,
  input wire [WIDTH-1:0] O_PORT_B_LINES_OE
);
  wire       le_ab = I_A_TO_B_TRANSPARENT_ENABLE;
  wire       le_ba = I_B_TO_A_TRANSPARENT_ENABLE;
  wire       ck_ab = I_A_TO_B_CAPTURE_CLOCK;
  wire       ck_ba = I_B_TO_A_CAPTURE_CLOCK;
  reg  [3:0] warm;
  wire       ok    = (warm == 4'hF);

  // Pipeline and synchroniser still fill after reset
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N)
      warm <= 4'h0;
    else if (!ok)
      warm <= warm + 4'h1;
  end

  default clocking dc @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  b_drive_en_a:
    assert property (ok |-> O_PORT_B_LINES_OE == {WIDTH{$past(I_A_TO_B_DRIVE_ENABLE, 3)}})
      else $error("port B enable wrong");
  a_drive_en_a:
    assert property (ok |-> O_PORT_A_LINES_OE == {WIDTH{!$past(I_B_TO_A_DRIVE_ENABLE_N, 3)}})
      else $error("port A enable wrong");
  ab_pass_a:
    assert property (ok && $past(le_ab, 3) |-> O_PORT_B_LINES == $past(I_PORT_A_LINES, 3))
      else $error("A to B pass wrong");
  ab_capture_a:
    assert property (ok && !$past(le_ab, 3) && $past(ck_ab, 3) && !$past(ck_ab, 4)
      |-> O_PORT_B_LINES == $past(I_PORT_A_LINES, 3)) else $error("A to B capture wrong");
  ab_hold_a:
    assert property (ok && !$past(le_ab, 3) && !($past(ck_ab, 3) && !$past(ck_ab, 4))
      |-> $stable(O_PORT_B_LINES)) else $error("A to B hold broken");
  ba_pass_a:
    assert property (ok && $past(le_ba, 3) |-> O_PORT_A_LINES == $past(I_PORT_B_LINES, 3))
      else $error("B to A pass wrong");
  ba_capture_a:
    assert property (ok && !$past(le_ba, 3) && $past(ck_ba, 3) && !$past(ck_ba, 4)
      |-> O_PORT_A_LINES == $past(I_PORT_B_LINES, 3)) else $error("B to A capture wrong");
  ba_hold_a:
    assert property (ok && !$past(le_ba, 3) && !($past(ck_ba, 3) && !$past(ck_ba, 4))
      |-> $stable(O_PORT_A_LINES)) else $error("B to A hold broken");
endmodule // brt_props

bind brt_transceiver brt_props #(.WIDTH(WIDTH)) u_props (.*);

// ### verification/brt_bus_agent.sv
`timescale 1ns/1ps

module brt_bus_agent #(
  parameter WIDTH = 18
) (
  // Agent levels
  input  wire [WIDTH-1:0] i_a_data,
  input  wire [WIDTH-1:0] i_b_data,
  // Device drivers
  input  wire [WIDTH-1:0] i_dev_a,
  input  wire [WIDTH-1:0] i_dev_a_oe,
  input  wire [WIDTH-1:0] i_dev_b,
  input  wire [WIDTH-1:0] i_dev_b_oe,
  // Resolved wires
  output wire [WIDTH-1:0] o_a_wire,
  output wire [WIDTH-1:0] o_b_wire
);
  // Agents step off every line the device drives, so no contention
  assign o_a_wire = (i_dev_a & i_dev_a_oe) | (i_a_data & ~i_dev_a_oe);
  assign o_b_wire = (i_dev_b & i_dev_b_oe) | (i_b_data & ~i_dev_b_oe);
endmodule // brt_bus_agent

// ### verification/brt_transceiver_tb.sv
`timescale 1ns/1ps
`include "brt_consts.vh"

module brt_transceiver_tb;
  logic        I_CLOCK = 0, I_RST_N = 0, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
  logic        I_ARVALID = 0, I_RREADY = 0, I_A_TO_B_DRIVE_ENABLE = 0;
  logic        I_B_TO_A_DRIVE_ENABLE_N = 1, I_A_TO_B_TRANSPARENT_ENABLE = 0;
  logic        I_B_TO_A_TRANSPARENT_ENABLE = 0, I_A_TO_B_CAPTURE_CLOCK = 0;
  logic        I_B_TO_A_CAPTURE_CLOCK = 0;
  logic [2:0]  I_AWPROT = 3'h0, I_ARPROT = 3'h0;
  logic [3:0]  I_WSTRB = 4'hF;
  logic [4:0]  I_AWADDR = 5'h00, I_ARADDR = 5'h00;
  logic [31:0] I_WDATA = 32'h0000_0000, d;
  logic [17:0] a_val = 18'h0_0000, b_val = 18'h0_0000;
  logic [1:0]  r;
  wire  [17:0] I_PORT_A_LINES, I_PORT_B_LINES, O_PORT_A_LINES, O_PORT_B_LINES;
  wire  [17:0] O_PORT_A_LINES_OE, O_PORT_B_LINES_OE;
  wire         O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  wire  [1:0]  O_BRESP, O_RRESP;
  wire  [31:0] O_RDATA;
  int          err_total = 0;
  int          checks = 0;

  brt_transceiver dut (.*);

  brt_bus_agent agent (
    .i_a_data   (a_val),
    .i_b_data   (b_val),
    .i_dev_a    (O_PORT_A_LINES),
    .i_dev_a_oe (O_PORT_A_LINES_OE),
    .i_dev_b    (O_PORT_B_LINES),
    .i_dev_b_oe (O_PORT_B_LINES_OE),
    .o_a_wire   (I_PORT_A_LINES),
    .o_b_wire   (I_PORT_B_LINES)
  );

  initial begin
    forever #2 I_CLOCK = ~I_CLOCK;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge I_CLOCK);
  endtask

  task axw(input logic [4:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge I_CLOCK);
    I_AWADDR <= a;
    I_WDATA <= v;
    I_AWVALID <= 1;
    I_WVALID <= 1;
    I_BREADY <= 1;
    do begin
      @(posedge I_CLOCK);
      if (O_AWREADY) I_AWVALID <= 0;
      if (O_WREADY) I_WVALID <= 0;
    end while (!O_BVALID);
    resp = O_BRESP;
    I_BREADY <= 0;
  endtask

  task axr(input logic [4:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge I_CLOCK);
    I_ARADDR <= a;
    I_ARVALID <= 1;
    I_RREADY <= 1;
    do begin
      @(posedge I_CLOCK);
      if (O_ARREADY) I_ARVALID <= 0;
    end while (!O_RVALID);
    v = O_RDATA;
    resp = O_RRESP;
    I_RREADY <= 0;
  endtask

  task t_ab_path;
    I_A_TO_B_DRIVE_ENABLE <= 1;
    I_A_TO_B_TRANSPARENT_ENABLE <= 1;
    I_A_TO_B_CAPTURE_CLOCK <= 1;
    a_val <= 18'h2_5A5A;
    cyc(8);
    chk(I_PORT_B_LINES, 18'h2_5A5A, "ab pass");
    chk(O_PORT_B_LINES_OE, 18'h3_FFFF, "b enable");
    I_A_TO_B_TRANSPARENT_ENABLE <= 0;
    cyc(6);
    a_val <= 18'h1_0F0F;
    cyc(8);
    chk(I_PORT_B_LINES, 18'h2_5A5A, "ab high hold");
    I_A_TO_B_CAPTURE_CLOCK <= 0;
    cyc(8);
    chk(I_PORT_B_LINES, 18'h2_5A5A, "ab low hold");
    // Slow edges only, pins miss fast ones
    I_A_TO_B_CAPTURE_CLOCK <= 1;
    cyc(8);
    chk(I_PORT_B_LINES, 18'h1_0F0F, "ab capture");
  endtask

  task t_float;
    I_A_TO_B_DRIVE_ENABLE <= 0;
    I_A_TO_B_CAPTURE_CLOCK <= 0;
    a_val <= 18'h0_3C3C;
    cyc(8);
    chk(O_PORT_B_LINES_OE, 18'h0_0000, "b float");
    I_A_TO_B_CAPTURE_CLOCK <= 1;
    cyc(8);
    I_A_TO_B_DRIVE_ENABLE <= 1;
    cyc(8);
    chk(I_PORT_B_LINES, 18'h0_3C3C, "float capture");
  endtask

  task t_ba_path;
    I_A_TO_B_DRIVE_ENABLE <= 0;
    I_B_TO_A_DRIVE_ENABLE_N <= 0;
    I_B_TO_A_TRANSPARENT_ENABLE <= 1;
    b_val <= 18'h3_1234;
    cyc(8);
    chk(I_PORT_A_LINES, 18'h3_1234, "ba pass");
    chk(O_PORT_A_LINES_OE, 18'h3_FFFF, "a enable");
    I_B_TO_A_TRANSPARENT_ENABLE <= 0;
    cyc(6);
    b_val <= 18'h0_00FF;
    cyc(8);
    chk(I_PORT_A_LINES, 18'h3_1234, "ba hold");
    I_B_TO_A_CAPTURE_CLOCK <= 1;
    cyc(8);
    chk(I_PORT_A_LINES, 18'h0_00FF, "ba capture");
    chk(O_PORT_B_LINES, 18'h0_3C3C, "ab untouched");
    I_B_TO_A_DRIVE_ENABLE_N <= 1;
    cyc(8);
    chk(O_PORT_A_LINES_OE, 18'h0_0000, "a float");
  endtask

  task t_regs;
    axr(`BRT_REG_STATUS, d, r);
    chk(d, 32'h0000_0030, "status");
    axr(`BRT_REG_A2B_DATA, d, r);
    chk(d, 32'h0000_3C3C, "a2b data");
    axr(`BRT_REG_B2A_DATA, d, r);
    chk(d, 32'h0000_00FF, "b2a data");
    // Two A-to-B edges while latched, one B-to-A edge
    axr(`BRT_REG_A2B_COUNT, d, r);
    chk(d, 32'h0000_0002, "a2b count");
    axr(`BRT_REG_B2A_COUNT, d, r);
    chk(d, 32'h0000_0001, "b2a count");
    axr(5'h18, d, r);
    chk(r, `BRT_RESP_SLVERR, "rd unmapped");
    axw(`BRT_REG_CTRL, 32'h0000_0004, r);
    chk(r, `BRT_RESP_OKAY, "wr ctrl");
    axr(`BRT_REG_A2B_COUNT, d, r);
    chk(d, 32'h0000_0000, "count clear");
    axr(`BRT_REG_B2A_COUNT, d, r);
    chk(d, 32'h0000_0000, "b2a clear");
    axw(5'h1C, 32'hFFFF_FFFF, r);
    chk(r, `BRT_RESP_SLVERR, "wr unmapped");
  endtask

  task finish_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge I_CLOCK);
    I_RST_N <= 1;
    cyc(20);
    t_ab_path();
    t_float();
    t_ba_path();
    t_regs();
    finish_test();
  end

  // A hung handshake ends here
  initial begin
    #20000;
    err_total++;
    finish_test();
  end
endmodule // brt_transceiver_tb
